// ---- hw/rws_params.svh ----
`ifndef RWS_PARAMS_SVH
`define RWS_PARAMS_SVH

// APB byte offsets
`define RWS_OFF_CTRL 8'h00
`define RWS_OFF_STATUS 8'h04
`define RWS_OFF_FLAGS 8'h08

// Control register bits
`define RWS_CTRL_FAILSAFE 0
`define RWS_CTRL_SWDEV 1
`define RWS_CTRL_RESET 2'h0

// Flag register bits (write one to clear)
`define RWS_FLG_BADCFG 0
`define RWS_FLG_WDSTAT 1
`define RWS_FLG_CLAMPLO 2
`define RWS_FLG_CLAMPHI 3
`define RWS_FLG_EXTRST 4
`define RWS_FLG_CAUSECLR 8

// Serial frame fields
`define RWS_FRAME_BITS 16
`define RWS_FR_MODE_HI 15
`define RWS_FR_MODE_LO 13
`define RWS_FR_TOGGLE 12
`define RWS_FR_WDCFG 11
`define RWS_FR_WDWIN 10
`define RWS_FR_WDSEL_HI 9
`define RWS_FR_WDSEL_LO 7
`define RWS_FR_RDSEL 6
`define RWS_FR_UV_HI 5
`define RWS_FR_UV_LO 4
`define RWS_FR_RSTCFG 3

// Watchdog period select: 16 ms shifted left by the select value
`define RWS_WD_BASE_MS 11'h010
`define RWS_WD_SEL_MAX 3'h6
`define RWS_WD_SEL_DEFAULT 3'h4

// Timing
`define RWS_CLK_HZ 20000000
`define RWS_RD_LONG_MS 10
`define RWS_RD_SHORT_MS 2
`define RWS_RELAX_MS 1

`endif

// ---- hw/rws_pkg.sv ----
package rws_pkg;

    typedef enum logic [2:0] {
        RWS_INIT = 3'h0,
        RWS_NORMAL = 3'h1,
        RWS_STOP = 3'h2,
        RWS_FLASH = 3'h3,
        RWS_SLEEP = 3'h4,
        RWS_FAILSAFE = 3'h5,
        RWS_RESTART = 3'h6
    } rws_mode_t;

    // Mode selection field of a serial frame
    typedef enum logic [2:0] {
        RWS_REQ_READONLY = 3'h0,
        RWS_REQ_NORMAL = 3'h1,
        RWS_REQ_STOP = 3'h2,
        RWS_REQ_FLASH = 3'h3,
        RWS_REQ_SLEEP = 3'h4
    } rws_req_t;

    typedef enum logic [1:0] {
        RWS_PH_HOLD = 2'h0,
        RWS_PH_DELAY = 2'h1,
        RWS_PH_RELAX = 2'h2
    } rws_phase_t;

endpackage

// ---- hw/rws_supervisor.sv ----
// Overview of operation
// - After supply good, hold reset low for the delay, then release.
// - Threshold select and reset delay are set by serial writes.
// - Reset pin falling outside restart forces restart; still low afterwards is clamped.
// - Reset stuck high is checked only while the device drives reset.
// - Pin faults go to fail-safe or restart as set, and raise limp-home.
// - External pull-down forces restart with selected delay; long pull-down flagged clamped.
// - Watchdog is window or time-out type; keeps running in stop/flash.
// - Watchdog defaults to 256 ms time-out after reset.
// - Toggle bit resets to zero; first trigger writes one; long open window.
// - Software development mode: watchdog failure sets status and interrupt only.
// - Init: programmable, not running; normal: programmable and running.
// - Stop and flash modes freeze the watchdog settings.
// - Sleep, fail-safe, restart: watchdog off, settings back to default.
// - Trigger is a toggle of the bit, taken when chip select rises.
// - Time-out type: any trigger restarts period; period 16 to 1024 ms.
// - Refresh accepted with mode field normal, stop, flash or read-only.
// - Window type: closed half period after trigger, then open half.
// - Missing or early trigger drives reset low, restart or fail-safe.
// - After watchdog failure it restarts in normal with default time-out.
// - Watchdog failure is recorded in restart and limp-home cause bits.
// - New settings in normal need a trigger valid under old settings; timing restarts. Init takes them without one.
// - Invalid settings change keeps old settings and raises a flag.
`timescale 1ns/1ps
`default_nettype none
`include "rws_params.svh"

module rws_supervisor
    import rws_pkg::*;
#(
    parameter int CYC_PER_MS = `RWS_CLK_HZ / 1000,
    parameter int RD_LONG_MS = `RWS_RD_LONG_MS,
    parameter int RD_SHORT_MS = `RWS_RD_SHORT_MS,
    parameter int RELAX_MS = `RWS_RELAX_MS
)
(
    input wire logic clk, // 20 MHz clock
    input wire logic resetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped
    input wire logic sclk, // Serial clock pin
    input wire logic chipSelectN, // Serial chip select, low active
    input wire logic mosi, // Serial data in
    output logic miso, // Serial status out
    input wire logic resetPinIn, // Reset pin level
    output logic resetPinOut, // Reset pin drive value
    output logic resetPinOen, // Low while pulling reset low
    input wire logic vccOk, // Regulator above threshold
    output logic [1:0] uvThreshSel, // Threshold select
    output logic limpHome, // Limp-home output
    output logic intOut // Interrupt, high active
);

    localparam int DW = $clog2(CYC_PER_MS);
    localparam int NSYNC = 5;

    rws_mode_t mode;
    rws_phase_t phase;
    logic [DW-1:0] divCnt;
    logic msTick;
    logic [NSYNC-1:0] pinRaw;
    logic [2:0] syncQ [NSYNC];
    logic sclkS, sclkP, csS, csP, mosiS, roS, roP, vccS;
    logic [15:0] shiftIn, shiftOut;
    logic [4:0] bitCnt;
    logic frameDone;
    logic [1:0] ctrl;
    logic [10:0] wdCnt, rstCnt;
    logic wdWindow, openFirst, lastToggle, rdSel, powerUp, roDrive;
    logic [2:0] wdSel;
    logic badCfg, wdStat, clampLo, clampHi, extRst;
    logic [1:0] restartCause;
    logic [2:0] limpCause;
    logic [15:0] statusWord;
    logic wdRun, trigSeen, goodTrig, badTrig, timeout, wdFail, wdReset;
    logic cfgOk, cfgBad, inClosed, pinFaultLo, pinFaultHi, extPull;
    logic [10:0] periodMs, rdMs;
    logic apbWr, apbSetup;

    function automatic logic [10:0] periodOf(input logic [2:0] sel);
        periodOf = `RWS_WD_BASE_MS << sel;
    endfunction

    // Mode field values that carry a refresh
    function automatic logic refreshMode(input logic [2:0] req);
        refreshMode = (req == RWS_REQ_NORMAL) || (req == RWS_REQ_STOP) ||
                      (req == RWS_REQ_FLASH) || (req == RWS_REQ_READONLY);
    endfunction

    function automatic logic runMode(input rws_mode_t m);
        runMode = (m == RWS_NORMAL) || (m == RWS_STOP) || (m == RWS_FLASH);
    endfunction

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            divCnt <= '0;
            msTick <= 1'b0;
        end
        else
        begin
            msTick <= (divCnt == DW'(CYC_PER_MS - 1));
            divCnt <= (divCnt == DW'(CYC_PER_MS - 1)) ? '0 : divCnt + 1'b1;
        end
    end

    // Pins from outside the clock domain; stage 0 feeds only stage 1
    assign pinRaw = {vccOk, resetPinIn, mosi, chipSelectN, sclk};
    genvar g;
    generate
        for (g = 0; g < NSYNC; g++)
        begin : gSync
            always_ff @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                    syncQ[g] <= 3'h0;
                else
                    syncQ[g] <= {syncQ[g][1:0], pinRaw[g]};
            end
        end
    endgenerate

    assign sclkS = syncQ[0][1];
    assign sclkP = syncQ[0][2];
    assign csS = syncQ[1][1];
    assign csP = syncQ[1][2];
    assign mosiS = syncQ[2][1];
    assign roS = syncQ[3][1];
    assign roP = syncQ[3][2];
    assign vccS = syncQ[4][1];

    // Serial receiver and status shifter
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            shiftIn <= 16'h0000;
            shiftOut <= 16'h0000;
            bitCnt <= 5'h00;
            miso <= 1'b0;
        end
        else if (csP && !csS)
        begin
            bitCnt <= 5'h00;
            shiftOut <= statusWord;
            miso <= statusWord[15];
        end
        else if (!csS && sclkS && !sclkP)
        begin
            shiftIn <= {shiftIn[14:0], mosiS};
            if (bitCnt != 5'h1F)
                bitCnt <= bitCnt + 5'h01;
        end
        else if (!csS && !sclkS && sclkP)
        begin
            shiftOut <= {shiftOut[14:0], 1'b0};
            miso <= shiftOut[14];
        end
    end

    // frame taken at chip select rise
    assign frameDone = !csP && csS && (bitCnt == 5'(`RWS_FRAME_BITS));

    assign wdRun = runMode(mode);
    assign periodMs = periodOf(wdSel);
    // half period splits closed and open
    assign inClosed = wdWindow && !openFirst && (wdCnt < (periodMs >> 1));
    assign trigSeen = frameDone && refreshMode(shiftIn[`RWS_FR_MODE_HI:`RWS_FR_MODE_LO]) &&
                      (shiftIn[`RWS_FR_TOGGLE] != lastToggle);
    assign goodTrig = wdRun && trigSeen && !inClosed;
    assign badTrig = wdRun && trigSeen && inClosed;
    assign timeout = wdRun && msTick && (wdCnt == periodMs - 11'h001);
    assign wdFail = (timeout && !goodTrig) || badTrig;
    assign wdReset = wdFail && !ctrl[`RWS_CTRL_SWDEV];

    // new settings need a valid trigger, except in init
    assign cfgOk = frameDone && shiftIn[`RWS_FR_WDCFG] &&
                   (shiftIn[`RWS_FR_WDSEL_HI:`RWS_FR_WDSEL_LO] <= `RWS_WD_SEL_MAX) &&
                   ((mode == RWS_INIT) || ((mode == RWS_NORMAL) && goodTrig));
    assign cfgBad = frameDone && shiftIn[`RWS_FR_WDCFG] && !cfgOk &&
                    (runMode(mode) || (mode == RWS_INIT));

    assign rdMs = rdSel ? 11'(RD_SHORT_MS) : 11'(RD_LONG_MS);
    // clamped low after delay and relaxation
    assign pinFaultLo = (mode == RWS_RESTART) && (phase == RWS_PH_RELAX) && msTick &&
                        (rstCnt == 11'(RELAX_MS - 1)) && !roS;
    assign pinFaultHi = (mode == RWS_RESTART) && (phase == RWS_PH_DELAY) && msTick &&
                        (rstCnt >= 11'(RELAX_MS)) && roS;
    assign extPull = (mode != RWS_RESTART) && !roDrive && roP && !roS;

    // Mode and reset sequencer
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mode <= RWS_RESTART;
            phase <= RWS_PH_HOLD;
            rstCnt <= 11'h000;
            powerUp <= 1'b1;
        end
        else if (!vccS)
        begin
            mode <= RWS_RESTART;
            phase <= RWS_PH_HOLD;
            rstCnt <= 11'h000;
            powerUp <= 1'b1;
        end
        else if (pinFaultLo || pinFaultHi)
        begin
            mode <= ctrl[`RWS_CTRL_FAILSAFE] ? RWS_FAILSAFE : RWS_RESTART;
            phase <= RWS_PH_HOLD;
            rstCnt <= 11'h000;
        end
        else if (wdReset || extPull)
        begin
            mode <= (wdReset && ctrl[`RWS_CTRL_FAILSAFE]) ? RWS_FAILSAFE : RWS_RESTART;
            phase <= RWS_PH_HOLD;
            rstCnt <= 11'h000;
        end
        else
        begin
            case (mode)
                RWS_RESTART:
                begin
                    case (phase)
                        RWS_PH_HOLD:
                        begin
                            // Start on a tick so the delay is never a part ms short
                            if (msTick)
                                phase <= RWS_PH_DELAY;
                            rstCnt <= 11'h000;
                        end
                        RWS_PH_DELAY:
                        begin
                            if (msTick && rstCnt == rdMs - 11'h001)
                            begin
                                phase <= RWS_PH_RELAX;
                                rstCnt <= 11'h000;
                            end
                            else if (msTick)
                                rstCnt <= rstCnt + 11'h001;
                        end
                        RWS_PH_RELAX:
                        begin
                            if (msTick && rstCnt == 11'(RELAX_MS - 1))
                            begin
                                mode <= powerUp ? RWS_INIT : RWS_NORMAL;
                                powerUp <= 1'b0;
                                phase <= RWS_PH_HOLD;
                            end
                            else if (msTick)
                                rstCnt <= rstCnt + 11'h001;
                        end
                        default:
                            phase <= RWS_PH_HOLD;
                    endcase
                end
                RWS_INIT, RWS_NORMAL, RWS_STOP, RWS_FLASH:
                begin
                    if (frameDone)
                    begin
                        case (shiftIn[`RWS_FR_MODE_HI:`RWS_FR_MODE_LO])
                            RWS_REQ_NORMAL: mode <= RWS_NORMAL;
                            RWS_REQ_STOP: mode <= RWS_STOP;
                            RWS_REQ_FLASH: mode <= RWS_FLASH;
                            RWS_REQ_SLEEP: mode <= RWS_SLEEP;
                            default: mode <= mode;
                        endcase
                    end
                end
                RWS_SLEEP, RWS_FAILSAFE:
                begin
                    // Leaving needs a full reset sequence
                    if (frameDone && shiftIn[`RWS_FR_MODE_HI:`RWS_FR_MODE_LO] == RWS_REQ_NORMAL)
                    begin
                        mode <= RWS_RESTART;
                        phase <= RWS_PH_HOLD;
                    end
                end
                default:
                    mode <= RWS_RESTART;
            endcase
        end
    end

    // Reset pin drive; registered so the pin never glitches
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            roDrive <= 1'b1;
        else
            roDrive <= ((mode == RWS_RESTART) && (phase != RWS_PH_RELAX)) ||
                       (mode == RWS_FAILSAFE);
    end

    assign resetPinOut = 1'b0;
    assign resetPinOen = !roDrive;

    // Watchdog timer and settings
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wdWindow <= 1'b0;
            wdSel <= `RWS_WD_SEL_DEFAULT;
            wdCnt <= 11'h000;
            openFirst <= 1'b1;
            lastToggle <= 1'b0;
        end
        else
        begin
            if (trigSeen && (mode != RWS_RESTART))
                lastToggle <= shiftIn[`RWS_FR_TOGGLE];
            if (mode == RWS_RESTART)
                lastToggle <= 1'b0;
            if (mode == RWS_SLEEP || mode == RWS_FAILSAFE || mode == RWS_RESTART)
            begin
                wdWindow <= 1'b0;
                wdSel <= `RWS_WD_SEL_DEFAULT;
            end
            else if (cfgOk)
            begin
                wdWindow <= shiftIn[`RWS_FR_WDWIN];
                wdSel <= shiftIn[`RWS_FR_WDSEL_HI:`RWS_FR_WDSEL_LO];
            end
            // timer runs only in running modes
            if (!wdRun || goodTrig || wdFail)
            begin
                wdCnt <= 11'h000;
                openFirst <= !wdRun;
            end
            else if (msTick)
                wdCnt <= wdCnt + 11'h001;
        end
    end

    // Reset threshold and delay choice
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdSel <= 1'b0;
            uvThreshSel <= 2'h0;
        end
        else if (frameDone && shiftIn[`RWS_FR_RSTCFG])
        begin
            rdSel <= shiftIn[`RWS_FR_RDSEL];
            uvThreshSel <= shiftIn[`RWS_FR_UV_HI:`RWS_FR_UV_LO];
        end
    end

    assign apbSetup = psel && !penable;
    assign apbWr = psel && penable && pwrite;

    // Flags: hardware set wins over software clear
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            {badCfg, wdStat, clampLo, clampHi, extRst} <= 5'h00;
            restartCause <= 2'h0;
            limpCause <= 3'h0;
            limpHome <= 1'b0;
        end
        else
        begin
            if (apbWr && paddr == `RWS_OFF_FLAGS)
            begin
                if (pwdata[`RWS_FLG_BADCFG]) badCfg <= 1'b0;
                if (pwdata[`RWS_FLG_WDSTAT]) wdStat <= 1'b0;
                if (pwdata[`RWS_FLG_CLAMPLO]) clampLo <= 1'b0;
                if (pwdata[`RWS_FLG_CLAMPHI]) clampHi <= 1'b0;
                if (pwdata[`RWS_FLG_EXTRST]) extRst <= 1'b0;
                if (pwdata[`RWS_FLG_CAUSECLR])
                begin
                    restartCause <= 2'h0;
                    limpCause <= 3'h0;
                    limpHome <= 1'b0;
                end
            end
            if (cfgBad)
                badCfg <= 1'b1;
            if (wdFail && ctrl[`RWS_CTRL_SWDEV])
                wdStat <= 1'b1;
            if (extPull)
            begin
                extRst <= 1'b1;
                restartCause <= 2'h2;
            end
            if (wdReset)
            begin
                restartCause <= 2'h1;
                limpCause <= 3'h1;
                if (ctrl[`RWS_CTRL_FAILSAFE])
                    limpHome <= 1'b1;
            end
            if (pinFaultLo || pinFaultHi)
            begin
                clampLo <= clampLo | pinFaultLo;
                clampHi <= clampHi | pinFaultHi;
                limpCause <= pinFaultLo ? 3'h2 : 3'h3;
                limpHome <= 1'b1;
            end
            if (!vccS)
                restartCause <= 2'h3;
        end
    end

    // development mode failure signalled on interrupt
    assign intOut = badCfg | wdStat;

    assign statusWord = {mode, wdWindow, wdSel, restartCause, limpCause,
                         badCfg, wdStat, clampLo, clampHi};

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ctrl <= `RWS_CTRL_RESET;
        else if (apbWr && paddr == `RWS_OFF_CTRL)
            ctrl <= pwdata[1:0];
    end

    // Read data captured in the setup cycle
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            prdata <= 32'h0000_0000;
        else if (apbSetup)
        begin
            case (paddr)
                `RWS_OFF_CTRL: prdata <= {30'h0, ctrl};
                `RWS_OFF_STATUS: prdata <= {16'h0000, statusWord};
                `RWS_OFF_FLAGS: prdata <= {22'h0, limpHome, 4'h0, extRst, clampHi,
                                           clampLo, wdStat, badCfg};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && (paddr != `RWS_OFF_CTRL) &&
                     (paddr != `RWS_OFF_STATUS) && (paddr != `RWS_OFF_FLAGS);

endmodule
`default_nettype wire

// ---- bench/rws_supervisor_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module rws_supervisor_checker #(
    parameter int CYC_PER_MS = 20,
    parameter int RD_SHORT_MS = 2,
    parameter int RELAX_MS = 1
)
(
    input wire logic clk, // Clock
    input wire logic resetn, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Write
    input wire logic [7:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic chipSelectN, // Frame select
    input wire logic resetPinIn, // Pin level
    input wire logic resetPinOut, // Pin value
    input wire logic resetPinOen, // Pin enable
    input wire logic vccOk, // Supply good
    input wire logic [1:0] uvThreshSel, // Threshold
    input wire logic limpHome // Limp-home
);
    localparam int MIN_LOW = RD_SHORT_MS * CYC_PER_MS;
    localparam int PULL_MAX = RELAX_MS * CYC_PER_MS + 8;
    logic [15:0] lowCnt;
    logic clrReq;
    assign clrReq = psel && penable && pwrite && paddr == 8'h08 && pwdata[8];
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Saturates so a fail-safe stay cannot wrap
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            lowCnt <= 16'h0000;
        else if (resetPinOen)
            lowCnt <= 16'h0000;
        else if (lowCnt != 16'hFFFF)
            lowCnt <= lowCnt + 16'h0001;
    end
    sequence s_setup;
        psel && !penable ##1 psel && penable;
    endsequence
    sequence s_pull;
        resetPinOen && $fell(resetPinIn);
    endsequence
    chk_apb_ready: assert property (s_setup |-> pready)
        else $error("access phase not ready");
    chk_unmapped_err: assert property (s_setup |-> pslverr == !(paddr inside {0, 4, 8}))
        else $error("slave error does not match address");
    chk_pin_open: assert property (resetPinOut == 1'b0)
        else $error("reset pin driven high");
    chk_release_delay: assert property ($rose(resetPinOen) |-> lowCnt >= MIN_LOW)
        else $error("reset released too early");
    chk_vcc_hold: assert property (!vccOk [*5] |-> !resetPinOen)
        else $error("reset released without supply");
    chk_ext_pull: assert property (s_pull |-> ##[1:PULL_MAX] !resetPinOen)
        else $error("outside pull not answered by reset");
    chk_limp_sticky: assert property ($fell(limpHome) |-> $past(clrReq))
        else $error("limp-home dropped without clear");
    chk_uv_frame: assert property ($changed(uvThreshSel) |-> $past(chipSelectN, 3))
        else $error("threshold changed inside a frame");
endmodule
bind rws_supervisor rws_supervisor_checker #(.CYC_PER_MS(CYC_PER_MS), .RD_SHORT_MS(RD_SHORT_MS),
    .RELAX_MS(RELAX_MS)) chk (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .chipSelectN(chipSelectN), .resetPinIn(resetPinIn), .resetPinOut(resetPinOut),
    .resetPinOen(resetPinOen), .vccOk(vccOk), .uvThreshSel(uvThreshSel), .limpHome(limpHome));
`default_nettype wire

// ---- bench/rws_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rws_host_model
(
    output logic sclk, // Link clock
    output logic chipSelectN, // Frame select
    output logic mosi, // Data to device
    input wire logic miso // Status from device
);
    logic [15:0] rx;
    initial
    begin
        sclk = 1'b0;
        chipSelectN = 1'b1;
        mosi = 1'b0;
    end
    task automatic send(input logic [15:0] f);
        chipSelectN <= 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            mosi <= f[i];
            #200 sclk <= 1'b1;
            rx = {rx[14:0], miso};
            #200 sclk <= 1'b0;
        end
        #200 chipSelectN <= 1'b1;
        // Idle line must not show a stale bit
        mosi <= ~mosi;
        #400;
    endtask
endmodule
`default_nettype wire

// ---- bench/rws_supervisor_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "rws_params.svh"
module rws_supervisor_test;
    import rws_pkg::*;
    logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, vccOk = 0, pull = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, m;
    logic pready, pslverr, sclk, chip_select_pin, mosi, miso, pin, pinOut, pinOen, limpHome, intOut;
    logic [1:0] uvSel, uv;
    logic [32:0] expQ[$];
    logic [31:0] mskQ[$];
    int errTotal = 0, checked = 0, cyc = 0;
    assign pin = !pull && (pinOen || pinOut);
    always #25 clk = ~clk;
    rws_supervisor #(.CYC_PER_MS(20), .RD_LONG_MS(10), .RD_SHORT_MS(2), .RELAX_MS(1)) dut (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sclk(sclk), .chipSelectN(chip_select_pin), .mosi(mosi), .miso(miso), .resetPinIn(pin),
        .resetPinOut(pinOut), .resetPinOen(pinOen), .vccOk(vccOk), .uvThreshSel(uvSel),
        .limpHome(limpHome), .intOut(intOut));
    rws_host_model host (.sclk(sclk), .chipSelectN(chip_select_pin), .mosi(mosi), .miso(miso));
    task summarize;
        $display("Errors %0d, compares %0d", errTotal, checked);
        if (errTotal == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chkReg(input logic [32:0] g, e);
        checked++;
        if (g !== e)
        begin
            errTotal++;
            $display("Error %0t: read %h expected %h", $time, g, e);
        end
    endtask
    task chkPin(input logic [1:0] g, e);
        checked++;
        if (g !== e)
        begin
            errTotal++;
            $display("Error %0t: pin %b expected %b", $time, g, e);
        end
    endtask
    task w(input int n);
        repeat (n) @(posedge clk);
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        psel <= 0;
        penable <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, mk, input logic er);
        expQ.push_back({er, e & mk});
        mskQ.push_back(mk);
        apb(0, a, 0);
    endtask
    function automatic logic [15:0] fr(input logic [2:0] md, input logic t, c, wn,
        input logic [2:0] s, input logic rs, input logic [1:0] u, input logic rc);
        return {md, t, c, wn, s, rs, u, rc, 3'h0};
    endfunction
    always @(posedge clk)
    begin
        if (psel && penable && pready && !pwrite && expQ.size() > 0)
        begin
            m = mskQ.pop_front();
            chkReg({pslverr, prdata & m}, expQ.pop_front());
        end
    end
    // Whole plan needs about 14000 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errTotal++;
            summarize();
        end
    end
    initial
    begin
        void'($urandom(32'hF26E));
        uv = 2'($urandom_range(3, 1));
        w(6);
        resetn <= 1;
        w(10);
        vccOk <= 1;
        w(300);
        chkPin({1'b0, pin}, 2'h1);
        rd(`RWS_OFF_STATUS, 32'h0800, 32'hFE00, 0);
        rd(`RWS_OFF_CTRL, 0, 32'h3, 0);
        rd(8'h0C, 0, 32'hFFFFFFFF, 1);
        host.send(fr(0, 0, 0, 0, 0, 1, uv, 1));
        w(8);
        chkReg({17'h0, host.rx & 16'hFF80}, {17'h0, 16'h0980});
        chkPin(uvSel, uv);
        host.send(fr(1, 0, 0, 0, 0, 0, 0, 0));
        w(8);
        rd(`RWS_OFF_STATUS, 32'h2800, 32'hFE00, 0);
        host.send(fr(1, 1, 1, 1, 3'h1, 0, 0, 0));
        w(8);
        rd(`RWS_OFF_STATUS, 32'h3200, 32'hFE00, 0);
        host.send(fr(1, 0, 0, 0, 0, 0, 0, 0));
        w(10);
        chkPin({1'b0, pin}, 2'h0);
        w(100);
        rd(`RWS_OFF_STATUS, 32'h2880, 32'hFF80, 0);
        host.send(fr(1, 1, 1, 0, 3'h7, 0, 0, 0));
        w(8);
        chkPin({1'b0, intOut}, 2'h1);
        rd(`RWS_OFF_STATUS, 32'h2808, 32'hFE08, 0);
        apb(1, `RWS_OFF_FLAGS, 32'h11F);
        w(2);
        chkPin({1'b0, intOut}, 2'h0);
        pull <= 1;
        w(4);
        pull <= 0;
        w(8);
        chkPin({1'b0, pinOen}, 2'h0);
        w(100);
        rd(`RWS_OFF_FLAGS, 32'h10, 32'h10, 0);
        rd(`RWS_OFF_STATUS, 32'h2900, 32'hFF80, 0);
        w(1000);
        host.send(fr(1, 1, 0, 0, 0, 0, 0, 0));
        w(4600);
        chkPin({1'b0, pin}, 2'h1);
        w(1000);
        rd(`RWS_OFF_STATUS, 32'h2880, 32'hFF80, 0);
        apb(1, `RWS_OFF_CTRL, 32'h1);
        w(5300);
        chkPin({pinOen, limpHome}, 2'h1);
        rd(`RWS_OFF_STATUS, 32'hA000, 32'hE000, 0);
        apb(1, `RWS_OFF_FLAGS, 32'h100);
        w(2);
        chkPin({1'b0, limpHome}, 2'h0);
        summarize();
    end
endmodule
`default_nettype wire
